// >>> rtl/pesm_monitor.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
// Function
// - late error flags 18:16, set on late target while enable and notify are on
// - writing enable zero clears late flag
// - done flags 2:0 set when output generated while enable and notify are on
// - done flag cleared by writing one
// - output irq status gated per unit notify
// - capture irq status gated per capture enable
// - pin event irq is OR of status
// - output enable self-clears on output generated
module pesm_monitor #(
  parameter int N_OUT = pesm_pkg::NUM_OUT,
  parameter int N_CAP = pesm_pkg::NUM_CAP
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pesm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // unit side
  input wire pesm_pkg::pesm_events_t events,
  output pesm_pkg::pesm_ctrl_t ctrl,
  // interrupts
  output logic pin_event_irq,
  output logic irq
);
  import pesm_pkg::*;

  // the struct fields are sized by the package counts, so the parameters must match
  if (N_OUT != NUM_OUT || N_CAP != NUM_CAP)
  begin : g_count_check
    $error("pesm_monitor: unit counts must match the package");
  end

  // apb state
  logic ready_reg; // access phase answered
  logic [31:0] prdata_reg; // read data flop
  logic acc; // access phase in progress
  logic wr_en; // write takes effect this edge
  // address hits
  logic hit_flags, hit_int, hit_ctrl, hit_mask, hit_any;

  // control and flags
  logic [N_OUT-1:0] enable_reg; // output unit enable
  logic [N_OUT-1:0] notify_reg; // output_event_irq_enable
  logic [N_CAP-1:0] cap_en_reg; // capture_irq_enable
  logic [31:0] mask_reg; // interrupt mask
  logic [N_OUT-1:0] late_q, done_q; // flag vectors
  logic [N_OUT-1:0] late_set, late_clr, done_set, done_clr;
  logic [N_OUT+N_CAP-1:0] int_q, int_set, int_clr; // {out, cap}
  logic [31:0] flags_word, int_word, ctrl_word; // read views

  // picks the per-output-unit bits at lsb out of a write word
  function automatic logic [N_OUT-1:0] out_bits(input logic [31:0] d, input int lsb);
    out_bits = d[lsb +: N_OUT];
  endfunction
  // picks the per-capture-unit bits at lsb out of a write word
  function automatic logic [N_CAP-1:0] cap_bits(input logic [31:0] d, input int lsb);
    cap_bits = d[lsb +: N_CAP];
  endfunction

  // a one-cycle wait state keeps read data coming from a flop
  assign acc = psel & penable;
  assign wr_en = acc & pwrite & ready_reg;

  // address decode
  always_comb
  begin
    hit_flags = 1'b0;
    hit_int = 1'b0;
    hit_ctrl = 1'b0;
    hit_mask = 1'b0;
    if (paddr == OFF_FLAGS)
    begin
      hit_flags = 1'b1;
    end
    else if (paddr == OFF_INT_STATUS)
    begin
      hit_int = 1'b1;
    end
    else if (paddr == OFF_CTRL)
    begin
      hit_ctrl = 1'b1;
    end
    else if (paddr == OFF_INT_MASK)
    begin
      hit_mask = 1'b1;
    end
  end
  assign hit_any = hit_flags | hit_int | hit_ctrl | hit_mask;

  // ready toggles high for one cycle in each access phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= acc & ~ready_reg;
    end
  end
  assign pready = ready_reg;
  // unmapped addresses answer with an error, no side effect
  assign pslverr = ready_reg & ~hit_any;

  // read views; reserved bits read zero
  always_comb
  begin
    flags_word = RST_WORD;
    flags_word[FLAG_DONE_LSB +: N_OUT] = done_q;
    flags_word[FLAG_LATE_LSB +: N_OUT] = late_q;
    int_word = RST_WORD;
    int_word[INT_CAP_LSB +: N_CAP] = int_q[N_CAP-1:0];
    int_word[INT_OUT_LSB +: N_OUT] = int_q[N_OUT+N_CAP-1:N_CAP];
    ctrl_word = RST_WORD;
    ctrl_word[CTRL_EN_LSB +: N_OUT] = enable_reg;
    ctrl_word[CTRL_NOTIFY_LSB +: N_OUT] = notify_reg;
    ctrl_word[CTRL_CAP_LSB +: N_CAP] = cap_en_reg;
  end

  // read data is captured at the edge that raises pready
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= RST_WORD;
    end
    else if (acc & ~ready_reg & ~pwrite)
    begin
      if (hit_flags)
      begin
        prdata_reg <= flags_word;
      end
      else if (hit_int)
      begin
        prdata_reg <= int_word;
      end
      else if (hit_ctrl)
      begin
        prdata_reg <= ctrl_word;
      end
      else if (hit_mask)
      begin
        prdata_reg <= mask_reg;
      end
      else
      begin
        prdata_reg <= RST_WORD;
      end
    end
  end
  assign prdata = prdata_reg;

  // output unit enable: software sets or clears, generated output clears it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_reg <= '0;
    end
    else
    begin
      // hardware self-clear beats a same-cycle write: the unit has finished
      enable_reg <= (wr_en & hit_ctrl ? out_bits(pwdata, CTRL_EN_LSB) : enable_reg)
                    & ~events.out_done;
    end
  end

  // irq enables are plain read/write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      notify_reg <= '0;
      cap_en_reg <= '0;
    end
    else if (wr_en & hit_ctrl)
    begin
      notify_reg <= out_bits(pwdata, CTRL_NOTIFY_LSB);
      cap_en_reg <= cap_bits(pwdata, CTRL_CAP_LSB);
    end
  end

  // mask register, only implemented bits are kept
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_reg <= RST_WORD;
    end
    else if (wr_en & hit_mask)
    begin
      mask_reg <= pwdata & int_word_mask();
    end
  end

  // implemented bits of the status layout
  function automatic logic [31:0] int_word_mask();
    int_word_mask = RST_WORD;
    int_word_mask[INT_CAP_LSB +: N_CAP] = '1;
    int_word_mask[INT_OUT_LSB +: N_OUT] = '1;
  endfunction

  // flag set and clear terms
  always_comb
  begin
    // late only counts while the unit is armed and notify is on
    late_set = events.out_late & enable_reg & notify_reg;
    // a write of zero to an enable bit clears that unit's late flag
    late_clr = (wr_en & hit_ctrl) ? ~out_bits(pwdata, CTRL_EN_LSB) : '0;
    // late is also write-one-clear through the flags register
    if (wr_en & hit_flags)
    begin
      late_clr = late_clr | out_bits(pwdata, FLAG_LATE_LSB);
    end
    done_set = events.out_done & enable_reg & notify_reg;
    done_clr = (wr_en & hit_flags) ? out_bits(pwdata, FLAG_DONE_LSB) : '0;
    // per-unit interrupt status follows either output flag event
    int_set = {late_set | done_set, events.cap_event & cap_en_reg};
    int_clr = '0;
    if (wr_en & hit_int)
    begin
      int_clr = {out_bits(pwdata, INT_OUT_LSB), cap_bits(pwdata, INT_CAP_LSB)};
    end
  end

  // sticky storage
  pesm_sticky #(.W(N_OUT)) u_late (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_i(late_set),
    .clr_i(late_clr),
    .q(late_q)
  );
  pesm_sticky #(.W(N_OUT)) u_done (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_i(done_set),
    .clr_i(done_clr),
    .q(done_q)
  );
  pesm_sticky #(.W(N_OUT+N_CAP)) u_int (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_i(int_set),
    .clr_i(int_clr),
    .q(int_q)
  );

  // global pin event bit ignores the mask; irq honours it
  assign pin_event_irq = |int_q;
  assign irq = |(int_word & mask_reg);

  // unit control out
  assign ctrl.out_enable = enable_reg;
  assign ctrl.out_irq_en = notify_reg;
  assign ctrl.cap_irq_en = cap_en_reg;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic [N_OUT-1:0] out_int;
  assign out_int = int_q[N_OUT+N_CAP-1:N_CAP];

  a_late_flag_set: assert property ((late_set != '0) |=> ((late_q & $past(late_set)) == $past(late_set)))
    else $error("late flag missed");
  a_late_en_clear: assert property ((wr_en & hit_ctrl & (pwdata[CTRL_EN_LSB] == 1'b0) & ~late_set[0])
    |=> ~late_q[0])
    else $error("late flag kept after enable cleared");
  a_done_flag_set: assert property ((events.out_done[0] & enable_reg[0] & notify_reg[0]) |=> done_q[0] & out_int[0])
    else $error("done flag or status missed");
  a_done_w1c_clear: assert property ((wr_en & hit_flags & pwdata[FLAG_DONE_LSB] & ~done_set[0]) |=> ~done_q[0])
    else $error("done flag not cleared");
  a_done_zero_keep: assert property ((wr_en & hit_flags & ~pwdata[FLAG_DONE_LSB] & done_q[0]) |=> done_q[0])
    else $error("done flag lost on zero write");
  a_out_int_gate: assert property ((out_int & ~$past(out_int) & ~$past(notify_reg)) == '0)
    else $error("output status rose without notify");
  a_cap_int_gate: assert property ((int_q[N_CAP-1:0] & ~$past(int_q[N_CAP-1:0]) & ~$past(cap_en_reg)) == '0)
    else $error("capture status rose without enable");
  a_pin_irq_or: assert property (pin_event_irq == (int_word != RST_WORD))
    else $error("pin event irq not OR of status");
  a_int_w1c_clear: assert property ((wr_en & hit_int & pwdata[INT_CAP_LSB] & ~int_set[0]) |=> ~int_q[0])
    else $error("status bit not cleared");
  a_en_self_clear: assert property (events.out_done[1] |=> ~enable_reg[1])
    else $error("enable did not self-clear");
  a_apb_wait_one: assert property ((acc & ~ready_reg) |=> ready_reg ##1 ~ready_reg)
    else $error("apb answer not one wait state");

  c_done_irq: cover property (done_set[2] ##[1:20] irq);
  c_late_then_clear: cover property (late_set[1] ##[1:50] (wr_en & hit_ctrl & ~pwdata[1]));
  c_capture_int: cover property (int_set[1] ##1 pin_event_irq);
  c_set_clear_same: cover property ((done_set[0] & done_clr[0]));
endmodule

// >>> rtl/pesm_pkg.sv
package pesm_pkg;
  // unit counts
  localparam int NUM_OUT = 3;
  localparam int NUM_CAP = 2;
  // apb address width and register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_FLAGS = 12'h524; // output_event_flags
  localparam logic [11:0] OFF_INT_STATUS = 12'h528; // event_interrupt_status
  localparam logic [11:0] OFF_CTRL = 12'h540; // unit enables and irq enables
  localparam logic [11:0] OFF_INT_MASK = 12'h544; // mask, same layout as status
  // field positions
  localparam int FLAG_DONE_LSB = 0; // done flags 2:0
  localparam int FLAG_LATE_LSB = 16; // late flags 18:16
  localparam int INT_CAP_LSB = 0; // capture status 1:0
  localparam int INT_OUT_LSB = 16; // output status 18:16
  localparam int CTRL_EN_LSB = 0; // output unit enable 2:0
  localparam int CTRL_NOTIFY_LSB = 4; // output_event_irq_enable 6:4
  localparam int CTRL_CAP_LSB = 8; // capture_irq_enable 9:8
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // events from the units, one-cycle pulses on clk_sys
  typedef struct packed {
    logic [NUM_OUT-1:0] out_done; // output_event_unit generated its output
    logic [NUM_OUT-1:0] out_late; // target time already behind system time
    logic [NUM_CAP-1:0] cap_event; // input_capture_unit took a timestamp
  } pesm_events_t;
  // control towards the units
  typedef struct packed {
    logic [NUM_OUT-1:0] out_enable; // output unit enable
    logic [NUM_OUT-1:0] out_irq_en; // output_event_irq_enable
    logic [NUM_CAP-1:0] cap_irq_en; // capture_irq_enable
  } pesm_ctrl_t;
endpackage

// >>> rtl/pesm_sticky.sv
`timescale 1ns/1ns
// vector of sticky flags; a set in the clearing cycle wins
module pesm_sticky #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  // set after clear so a same-cycle event is not lost
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= (q_reg & ~clr_i) | set_i;
    end
  end
  assign q = q_reg;
endmodule

// >>> tb/ptp_event_status_monitor_bench.sv
`timescale 1ns/1ns
// self-checking bench driving the monitor's apb port and unit event pulses
module ptp_event_status_monitor_bench;
  import pesm_pkg::*;
  logic clk_sys = 1'b0; // 250 mhz system clock
  logic rst_n = 1'b0; // async reset, held at start
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [ADDR_W-1:0] paddr = '0; // apb byte address
  logic [31:0] pwdata = '0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready; // apb answer
  logic pslverr; // apb refusal
  pesm_events_t events = '0; // unit pulses
  pesm_ctrl_t ctrl; // unit control levels
  logic pin_event_irq; // or of status
  logic irq; // masked interrupt
  logic [31:0] rd_data; // last read word
  logic rd_err; // last slave error
  int failures = 0; // mismatch count
  int num_checks = 0; // comparison count

  // clock, half period 2 ns
  always #2 clk_sys = ~clk_sys;

  pesm_monitor DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .ctrl(ctrl), .pin_event_irq(pin_event_irq), .irq(irq));

  // verdict and end of run, shared with the watchdog
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one compare for every word or flag result
  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  // apb transfer; pready is sampled at the rising edge, where data and error are taken too
  // no cycle count is assumed, a hung slave is ended by the watchdog
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // read and compare against an expected word
  task rdc(input string n, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, exp, rd_data);
  endtask

  // one-cycle event pulse, result settled at the following negedge
  task pulse(input pesm_events_t e);
    @(posedge clk_sys);
    events <= e;
    @(posedge clk_sys);
    events <= '0;
    @(negedge clk_sys);
  endtask

  // all registers and the pin event irq output start cleared
  task t_reset;
    rdc("flags", OFF_FLAGS, 32'h0);
    rdc("status", OFF_INT_STATUS, 32'h0);
    rdc("ctrl", OFF_CTRL, 32'h0);
    rdc("mask", OFF_INT_MASK, 32'h0);
    chk("pin_irq", 32'h0, pin_event_irq);
    $display("test reset done");
  endtask

  // unmapped offset is refused and reads zero
  task t_unmapped;
    wr(12'h600, 32'hffff_ffff);
    chk("slverr", 32'h1, rd_err);
    rdc("unmapped", 12'h600, 32'h0);
    $display("test unmapped done");
  endtask

  // done event, self-clearing enable, mask, write-one-clear
  task t_done;
    wr(OFF_CTRL, 32'h77);
    pulse(8'h20);
    chk("enable", 32'h6, ctrl.out_enable);
    chk("pin_irq", 32'h1, pin_event_irq);
    chk("irq", 32'h0, irq);
    rdc("flags", OFF_FLAGS, 32'h1);
    rdc("status", OFF_INT_STATUS, 32'h1_0000);
    wr(OFF_INT_MASK, 32'h1_0000);
    chk("irq", 32'h1, irq);
    wr(OFF_FLAGS, 32'h0);
    rdc("flags", OFF_FLAGS, 32'h1);
    wr(OFF_FLAGS, 32'h1);
    rdc("flags", OFF_FLAGS, 32'h0);
    wr(OFF_INT_STATUS, 32'h1_0000);
    rdc("status", OFF_INT_STATUS, 32'h0);
    chk("pin_irq", 32'h0, pin_event_irq);
    chk("irq", 32'h0, irq);
    $display("test done done");
  endtask

  // late error on an enabled unit; disabled unit ignored; cleared by enable zero
  task t_late;
    wr(OFF_CTRL, 32'h72);
    chk("notify", 32'h7, ctrl.out_irq_en);
    pulse(8'h88);
    rdc("flags", OFF_FLAGS, 32'h2_0000);
    rdc("status", OFF_INT_STATUS, 32'h2_0000);
    wr(OFF_CTRL, 32'h70);
    rdc("flags", OFF_FLAGS, 32'h0);
    wr(OFF_INT_STATUS, 32'h2_0000);
    rdc("status", OFF_INT_STATUS, 32'h0);
    $display("test late done");
  endtask

  // units without notify raise nothing
  task t_notify;
    wr(OFF_CTRL, 32'h17);
    pulse(8'hc0);
    rdc("flags", OFF_FLAGS, 32'h0);
    rdc("status", OFF_INT_STATUS, 32'h0);
    $display("test notify done");
  endtask

  // capture status gated per unit enable
  task t_cap;
    wr(OFF_CTRL, 32'h200);
    chk("cap_en", 32'h2, ctrl.cap_irq_en);
    pulse(8'h03);
    rdc("status", OFF_INT_STATUS, 32'h2);
    chk("pin_irq", 32'h1, pin_event_irq);
    wr(OFF_INT_STATUS, 32'h3);
    rdc("status", OFF_INT_STATUS, 32'h0);
    $display("test capture done");
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_unmapped;
    t_done;
    t_late;
    t_notify;
    t_cap;
    results;
  end

  // watchdog, far beyond the roughly 135 cycles the tests need
  initial
  begin
    #20000;
    failures++;
    results;
  end
endmodule
